// file: rtl/ules_top.sv
// Purpose: Uncore event selector and counter with an APB register port.
// Assumes: Condition inputs are pclk-domain logic levels, one per cycle.
// Notes: Counter wraps at its width; a union of unit-mask bits counts once per cycle.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Count link 1 data-response credit stalls.
// - Count link 1 noncoherent bypass credit stalls.
// - Count link 1 noncoherent standard credit stalls.
// - Mask 07H counts any link 0 stall.
// - Mask 38H counts any link 1 stall.
// - Stalls count even when arbitration lost.
// - Count link 0 header buffer busy cycles.
// - Count link 1 header buffer busy cycles.
// - Count link 0 probe tracker stalls.
// - Count link 1 probe tracker stalls.
// - Count page opens per selected channel.
// - Every page open is a countable event.
// - Count idle-timer precharges per channel.
// - Count page-miss precharges, channels 0 and 1.
// - Page miss closes old page by precharge.
// - Count link 0 data-response credit stalls.
module ules_top #(
  parameter int COUNT_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ules_pkg::ules_link_cond_t link_cond,
  input wire ules_pkg::ules_dram_cond_t dram_cond,
  output logic event_hit,
  output logic [COUNT_W-1:0] event_count
);
  // The read path holds one 32-bit word, so a wider counter could not be read back.
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count_w
    $error("COUNT_W must be 1 to 32");
  end

  ules_pkg::ules_sel_t sel_q;
  logic enable_q;
  logic hit_q;
  logic hit;
  logic [COUNT_W-1:0] count_q;
  logic wr_en;
  logic rd_ok;
  logic clear_req;

  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign rd_ok = (paddr == ules_pkg::OFF_CTRL) | (paddr == ules_pkg::OFF_COUNT)
               | (paddr == ules_pkg::OFF_STATUS);
  assign pslverr = psel & penable & ~rd_ok;
  assign clear_req = wr_en & (paddr == ules_pkg::OFF_CTRL) & pwdata[ules_pkg::CTRL_CLEAR_BIT];

  // Selection and enable registers steer the counting logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
      enable_q <= 1'b0;
    end else if (wr_en && paddr == ules_pkg::OFF_CTRL) begin
      sel_q.event_code <= pwdata[ules_pkg::CTRL_EVENT_LSB +: 8];
      sel_q.unit_mask <= pwdata[ules_pkg::CTRL_UMASK_LSB +: 8];
      enable_q <= pwdata[ules_pkg::CTRL_ENABLE_BIT];
    end
  end

  ules_event_mux u_mux (
    .sel(sel_q),
    .link_c(link_cond),
    .dram_c(dram_cond),
    .hit(hit)
  );

  // The hit is registered to keep the counter adder off the condition paths.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit & enable_q;
    end
  end

  // One increment per qualifying cycle, never more, so a union counts once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= ules_pkg::COUNT_RESET[COUNT_W-1:0];
    end else if (wr_en && paddr == ules_pkg::OFF_COUNT) begin
      count_q <= pwdata[COUNT_W-1:0];
    end else if (clear_req) begin
      count_q <= hit_q ? COUNT_W'(1) : '0;
    end else if (hit_q) begin
      count_q <= count_q + COUNT_W'(1);
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        ules_pkg::OFF_CTRL: begin
          prdata[ules_pkg::CTRL_EVENT_LSB +: 8] = sel_q.event_code;
          prdata[ules_pkg::CTRL_UMASK_LSB +: 8] = sel_q.unit_mask;
          prdata[ules_pkg::CTRL_ENABLE_BIT] = enable_q;
        end
        ules_pkg::OFF_COUNT: begin
          prdata[COUNT_W-1:0] = count_q;
        end
        ules_pkg::OFF_STATUS: begin
          prdata[0] = hit_q;
        end
        default: begin
          prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  assign event_hit = hit_q;
  assign event_count = count_q;
endmodule : ules_top
`default_nettype wire

// file: rtl/ules_pkg.sv
// Purpose: Shared constants and types for the uncore link and DRAM event selector.
// Assumes: One uncore clock; registers reached over APB with 32-bit data.
// Notes: Event codes and unit masks are the hardware's own encodings.
package ules_pkg;
  localparam logic [7:0] EV_MULTIFLIT_STALL = 8'h41;
  localparam logic [7:0] EV_HEADER_BUSY = 8'h42;
  localparam logic [7:0] EV_PROBE_TRACKER = 8'h43;
  localparam logic [7:0] EV_PAGE_OPEN = 8'h60;
  localparam logic [7:0] EV_IDLE_CLOSE = 8'h61;
  localparam logic [7:0] EV_MISS_PRECHARGE = 8'h62;
  localparam logic [7:0] UM_L0_DATA_RESP = 8'h01;
  localparam logic [7:0] UM_L0_NC_BYPASS = 8'h02;
  localparam logic [7:0] UM_L0_NC_STD = 8'h04;
  localparam logic [7:0] UM_L1_DATA_RESP = 8'h08;
  localparam logic [7:0] UM_L1_NC_BYPASS = 8'h10;
  localparam logic [7:0] UM_L1_NC_STD = 8'h20;
  localparam logic [7:0] UM_HDR_L0 = 8'h02;
  localparam logic [7:0] UM_HDR_L1 = 8'h08;
  localparam logic [7:0] UM_PPT_L0 = 8'h01;
  localparam logic [7:0] UM_PPT_L1 = 8'h02;
  localparam logic [7:0] UM_CH0 = 8'h01;
  localparam logic [7:0] UM_CH1 = 8'h02;
  localparam logic [7:0] UM_CH2 = 8'h04;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_COUNT = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam int CTRL_EVENT_LSB = 0;
  localparam int CTRL_UMASK_LSB = 8;
  localparam int CTRL_ENABLE_BIT = 16;
  localparam int CTRL_CLEAR_BIT = 17;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] l0_vc_stall;
    logic [2:0] l1_vc_stall;
    logic l0_hdr_busy;
    logic l1_hdr_busy;
    logic l0_ppt_stall;
    logic l1_ppt_stall;
  } ules_link_cond_t;

  typedef struct packed {
    logic [2:0] page_open;
    logic [2:0] idle_close;
    logic [2:0] miss_precharge;
  } ules_dram_cond_t;

  typedef struct packed {
    logic [7:0] event_code;
    logic [7:0] unit_mask;
  } ules_sel_t;
endpackage : ules_pkg

// file: rtl/ules_event_mux.sv
// Purpose: Combinational event selection from event code and unit mask.
// Assumes: Conditions arrive registered on pclk.
// Notes: Unknown codes select nothing.
`timescale 1ns/1ps
`default_nettype none
module ules_event_mux (
  input wire ules_pkg::ules_sel_t sel,
  input wire ules_pkg::ules_link_cond_t link_c,
  input wire ules_pkg::ules_dram_cond_t dram_c,
  output logic hit
);
  logic [7:0] um;
  assign um = sel.unit_mask;

  always_comb begin
    hit = 1'b0;
    case (sel.event_code)
      ules_pkg::EV_MULTIFLIT_STALL: begin
        // Arbitration losses are not filtered out.
        hit = (|(um & ules_pkg::UM_L0_DATA_RESP) & link_c.l0_vc_stall[0])
            | (|(um & ules_pkg::UM_L0_NC_BYPASS) & link_c.l0_vc_stall[1])
            | (|(um & ules_pkg::UM_L0_NC_STD) & link_c.l0_vc_stall[2])
            | (|(um & ules_pkg::UM_L1_DATA_RESP) & link_c.l1_vc_stall[0])
            | (|(um & ules_pkg::UM_L1_NC_BYPASS) & link_c.l1_vc_stall[1])
            | (|(um & ules_pkg::UM_L1_NC_STD) & link_c.l1_vc_stall[2]);
      end
      ules_pkg::EV_HEADER_BUSY: begin
        hit = (|(um & ules_pkg::UM_HDR_L0) & link_c.l0_hdr_busy)
            | (|(um & ules_pkg::UM_HDR_L1) & link_c.l1_hdr_busy);
      end
      ules_pkg::EV_PROBE_TRACKER: begin
        hit = (|(um & ules_pkg::UM_PPT_L0) & link_c.l0_ppt_stall)
            | (|(um & ules_pkg::UM_PPT_L1) & link_c.l1_ppt_stall);
      end
      ules_pkg::EV_PAGE_OPEN: begin
        hit = |(um[2:0] & dram_c.page_open);
      end
      ules_pkg::EV_IDLE_CLOSE: begin
        hit = |(um[2:0] & dram_c.idle_close);
      end
      ules_pkg::EV_MISS_PRECHARGE: begin
        // Only channels 0 and 1 carry this event.
        hit = |(um[1:0] & dram_c.miss_precharge[1:0]);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end
endmodule : ules_event_mux
`default_nettype wire

// file: bench/ules_top_sva.sv
// Purpose: Port checks for ules_top.
// Assumes: Only top ports are seen.
// Notes: Selection is hidden here, so counting is judged step by step.
`timescale 1ns/1ps
`default_nettype none
module ules_top_sva #(
  parameter int COUNT_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic event_hit,
  input wire logic [COUNT_W-1:0] event_count
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire map = paddr inside {ules_pkg::OFF_CTRL, ules_pkg::OFF_COUNT, ules_pkg::OFF_STATUS};
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_bad: assert property (acc && !map |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_good: assert property (acc && map |-> !pslverr) else $error("mapped access refused");
  a_count_read: assert property (rd && paddr == ules_pkg::OFF_COUNT |-> prdata == event_count)
    else $error("count read wrong");
  a_status_read: assert property (rd && paddr == ules_pkg::OFF_STATUS |-> prdata == 32'(event_hit))
    else $error("status read wrong");
  a_count_step: assert property (event_hit && !psel |=> event_count == $past(event_count) + 1'b1)
    else $error("count did not step");
  a_count_hold: assert property (!event_hit && !(acc && pwrite) |=> $stable(event_count))
    else $error("count moved without hit");
  a_hit_off: assert property (acc && pwrite && paddr == ules_pkg::OFF_CTRL
    && !pwdata[ules_pkg::CTRL_ENABLE_BIT] |-> ##2 !event_hit [*2])
    else $error("hit while disabled");
endmodule : ules_top_sva
bind ules_top ules_top_sva #(.COUNT_W(COUNT_W)) u_ules_top_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_hit(event_hit),
  .event_count(event_count));
`default_nettype wire

// file: bench/ules_cond_src.sv
// Purpose: Far-side source of link and DRAM conditions.
// Assumes: Link bits sit above DRAM bits in the pattern.
// Notes: Outputs drop to zero between bursts, as quiet units do.
`timescale 1ns/1ps
`default_nettype none
module ules_cond_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [18:0] pat,
  output var ules_pkg::ules_link_cond_t link_cond,
  output var ules_pkg::ules_dram_cond_t dram_cond
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {link_cond, dram_cond} <= 19'h0_0000;
    end else begin
      {link_cond, dram_cond} <= go ? pat : 19'h0_0000;
    end
  end
endmodule : ules_cond_src
`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for ules_top.
// Assumes: Zero-wait APB; conditions come from ules_cond_src.
// Notes: Rows hold {code, mask, pattern, kind}; kind 2 runs disabled.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, event_count;
  logic pready, pslverr, er, event_hit;
  logic [18:0] pat = 19'h0_0000;
  logic go = 1'b0;
  ules_pkg::ules_link_cond_t link_cond;
  ules_pkg::ules_dram_cond_t dram_cond;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [39:0] tbl [21] = '{
    40'h41_0802_0001, 40'h41_1004_0001, 40'h41_2008_0001, 40'h41_0730_0001,
    40'h41_381E_0001, 40'h41_0110_0001, 40'h41_0810_0000, 40'h41_0802_0002,
    40'h42_0201_0001, 40'h42_0800_8001, 40'h43_0100_4001, 40'h43_0200_2001,
    40'h60_0100_0401, 40'h60_0200_0801, 40'h60_0400_1001, 40'h61_0100_0081,
    40'h61_0200_0101, 40'h61_0400_0201, 40'h62_0100_0011, 40'h62_0200_0021,
    40'h62_0400_0040};
  always #2.5 pclk = ~pclk;
  ules_top #(.COUNT_W(32)) u_ules_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_cond(link_cond), .dram_cond(dram_cond),
    .event_hit(event_hit), .event_count(event_count));
  ules_cond_src u_ules_cond_src (.pclk(pclk), .presetn(presetn), .go(go), .pat(pat),
    .link_cond(link_cond), .dram_cond(dram_cond));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run_row(input logic [39:0] r);
    apb(1'b1, ules_pkg::OFF_CTRL, {14'h0000, 1'b1, r[3:0] != 4'h2, r[31:24], r[39:32]});
    pat <= r[22:4];
    go <= 1'b1;
    repeat (3) @(posedge pclk);
    // The pattern was seen at the previous edge, so the hit flag stands now.
    check({31'h0000_0000, event_hit}, {31'h0000_0000, r[3:0] == 4'h1});
    go <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, ules_pkg::OFF_COUNT, 32'h0000_0000);
    check(rd, (r[3:0] == 4'h1) ? 32'h0000_0003 : 32'h0000_0000);
  endtask : run_row
  task automatic t_regs();
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check({31'h0000_0000, er}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, ules_pkg::OFF_COUNT, 32'h0000_0005);
    apb(1'b0, ules_pkg::OFF_COUNT, 32'h0000_0000);
    check(rd, 32'h0000_0005);
    // The last row left code 62H, mask 04H, enabled; the clear bit is not kept.
    apb(1'b0, ules_pkg::OFF_CTRL, 32'h0000_0000);
    check(rd, 32'h0001_0462);
    apb(1'b0, ules_pkg::OFF_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask : t_regs
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ules_pkg::OFF_COUNT, 32'h0000_0000);
    check(rd, ules_pkg::COUNT_RESET);
    foreach (tbl[i]) run_row(tbl[i]);
    t_regs();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
